// *** src/mri_consts.svh ***
`ifndef MRI_CONSTS_SVH
`define MRI_CONSTS_SVH

// ****************************************
// opcode patterns
// ****************************************
`define MRI_OP_FILE_TO_ACC_HI  7'h10
`define MRI_OP_LIT_TO_ACC_HI   6'h19
`define MRI_OP_ACC_TO_FILE_HI  7'h01
`define MRI_OP_ACC_TO_SPEC_HI  8'h00
`define MRI_OP_IDLE            14'h0000
`define MRI_OP_SUB_EXIT        14'h0040
`define MRI_OP_INT_EXIT        14'h0060
// ****************************************
// reset values
// ****************************************
`define MRI_ACC_RST            8'h00
`define MRI_PC_RST             11'h000
`define MRI_GIE_RST            1'b0
`endif

// *** src/mri_decode.sv ***
`include "mri_consts.svh"
// ****************************************
// move and return execute stage
// ****************************************
module mri_decode
   import mri_pkg::*;
(
   input  wire logic                ref_clk_i,
   input  wire logic                rst_i,
   input  wire mri_pkg::mri_instr_t instr_i,
   input  wire logic                instr_valid_i,
   input  wire mri_pkg::mri_byte_t  file_rdata_i,
   input  wire mri_pkg::mri_pc_t    stack_top_entry_i,
   output logic                     instr_ready_o,
   output mri_pkg::mri_byte_t       accumulator_o,
   output mri_pkg::mri_pc_t         pc_o,
   output logic [6:0]               file_addr_o,
   output logic                     file_we_o,
   output mri_pkg::mri_byte_t       file_wdata_o,
   output logic [5:0]               spec_addr_o,
   output logic                     spec_we_o,
   output mri_pkg::mri_byte_t       spec_wdata_o,
   output logic                     stack_pop_o,
   output logic                     global_interrupt_enable_o,
   output logic                     flags_we_o
);
   import mri_pkg::*;

   logic f2a, l2a, a2f, a2s, idl, sxit, ixit;
   mri_state_t state_r, state_nxt;
   mri_byte_t  acc_r, acc_nxt;
   mri_pc_t    pc_r, pc_nxt;
   logic       gie_r, gie_nxt;
   logic [6:0] faddr_r;
   logic [5:0] saddr_r;
   logic       fwe_r, swe_r, pop_r;
   logic       ready_r;
   mri_byte_t  fwd_r, swd_r;

   mri_opdec u_opdec (
      .instr_i       (instr_i),
      .file_to_acc_o (f2a),
      .lit_to_acc_o  (l2a),
      .acc_to_file_o (a2f),
      .acc_to_spec_o (a2s),
      .idle_o        (idl),
      .sub_exit_o    (sxit),
      .int_exit_o    (ixit)
   );

   // ****************************************
   // next-state decode
   // ****************************************
   wire exec_w   = instr_valid_i && (state_r == MRI_ST_EXEC);
   wire ret_w    = exec_w && (sxit || ixit);

   // ****************************************
   // write selects
   // ****************************************
   // the opcode fields never overlap, so no priority is needed here
   wire file_hit_w = exec_w && a2f;
   wire spec_hit_w = exec_w && a2s;
   // file read data is combinational from the addressed register
   assign file_addr_o = exec_w ? instr_i[6:0] : faddr_r;

   // a return load overrides the plain counter step
   always_comb begin
      state_nxt = state_r;
      acc_nxt   = acc_r;
      pc_nxt    = pc_r;
      gie_nxt   = gie_r;
      case (state_r)
         MRI_ST_EXEC: begin
            if (exec_w) begin
               pc_nxt = mri_pc_t'(pc_r + 11'h001);
               if (f2a) acc_nxt = file_rdata_i;
               if (l2a) acc_nxt = instr_i[7:0];
               if (ret_w) begin
                  pc_nxt    = stack_top_entry_i;
                  state_nxt = MRI_ST_FLUSH;
               end
               if (ixit) gie_nxt = 1'b1;
            end
         end
         MRI_ST_FLUSH: state_nxt = MRI_ST_EXEC;
         default: state_nxt = MRI_ST_EXEC;
      endcase
   end

   // ****************************************
   // core state
   // ****************************************
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_r <= MRI_ST_EXEC;
         acc_r   <= `MRI_ACC_RST;
         pc_r    <= `MRI_PC_RST;
         gie_r   <= `MRI_GIE_RST;
      end else begin
         state_r <= state_nxt;
         acc_r   <= acc_nxt;
         pc_r    <= pc_nxt;
         gie_r   <= gie_nxt;
      end
   end

   // ****************************************
   // fetch ready flag
   // ****************************************
   // a flop rather than a state decode, so the handshake output is glitch free
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ready_r <= 1'b1;
      end else begin
         ready_r <= (state_nxt == MRI_ST_EXEC);
      end
   end

   // ****************************************
   // registered write and pop strobes
   // ****************************************
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         fwe_r   <= 1'b0;
         swe_r   <= 1'b0;
         pop_r   <= 1'b0;
         faddr_r <= 7'h00;
         saddr_r <= 6'h00;
         fwd_r   <= 8'h00;
         swd_r   <= 8'h00;
      end else begin
         fwe_r <= file_hit_w;
         swe_r <= spec_hit_w;
         pop_r <= ret_w;
         if (exec_w) begin
            faddr_r <= instr_i[6:0];
            saddr_r <= instr_i[5:0];
            fwd_r   <= acc_r;
            swd_r   <= acc_r;
         end
      end
   end

   // flags never written by this group
   assign flags_we_o                = 1'b0;
   assign instr_ready_o             = ready_r;
   assign accumulator_o             = acc_r;
   assign pc_o                      = pc_r;
   assign file_we_o                 = fwe_r;
   assign file_wdata_o              = fwd_r;
   assign spec_addr_o               = saddr_r;
   assign spec_we_o                 = swe_r;
   assign spec_wdata_o              = swd_r;
   assign stack_pop_o               = pop_r;
   assign global_interrupt_enable_o = gie_r;

   // ****************************************
   // checks
   // ****************************************
   chk_lit_load: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && l2a |=> acc_r == $past(instr_i[7:0])) else $error("literal not loaded");
   chk_file_load: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && f2a |=> acc_r == $past(file_rdata_i)) else $error("file not loaded");
   chk_file_wr: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && a2f |=> fwe_r && fwd_r == $past(acc_r)) else $error("file write bad");
   chk_spec_wr: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && a2s |=> swe_r && saddr_r == $past(instr_i[5:0])) else $error("spec write bad");
   chk_idle_none: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && idl |=> !fwe_r && !swe_r && $stable(acc_r) && pc_r == $past(pc_r) + 11'h001)
      else $error("idle changed state");
   sequence ret_seq;
      ret_w ##1 (pop_r && state_r == MRI_ST_FLUSH);
   endsequence
   chk_ret_pc: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ret_w |=> pc_r == $past(stack_top_entry_i)) else $error("pc not restored");
   chk_ret_two: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ret_w |-> ret_seq ##1 instr_ready_o) else $error("return not two cycles");
   chk_int_exit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && ixit |=> pop_r && pc_r == $past(stack_top_entry_i)) else $error("int exit pop");
   chk_gie_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && ixit |=> gie_r ##1 gie_r && instr_ready_o) else $error("gie not set");

   // ****************************************
   // dead cycle and side effect checks
   // ****************************************
   // the dead cycle after a return: any word on the bus is dropped
   sequence dead_cycle_seq;
      state_r == MRI_ST_FLUSH && !instr_ready_o;
   endsequence
   // nothing seen in the dead cycle may reach a register or a strobe
   sequence quiet_seq;
      $stable(acc_r) && $stable(pc_r) && !fwe_r && !swe_r && !pop_r;
   endsequence
   chk_dead_refuse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      dead_cycle_seq |=> quiet_seq) else $error("word taken in dead cycle");
   // interrupt exit: pop, one dead cycle, then fetch reopens with the enable set
   sequence int_tail_seq;
      pop_r && !instr_ready_o ##1 instr_ready_o && gie_r;
   endsequence
   chk_int_tail: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && ixit |=> int_tail_seq) else $error("int exit tail bad");
   // every one-cycle word steps the counter by exactly one
   chk_pc_step: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && !ret_w |=> pc_r == $past(pc_r) + 11'h001) else $error("pc did not step");
   // the pop is a single pulse, and fetch is open again once it is gone
   chk_pop_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      pop_r |=> !pop_r && instr_ready_o) else $error("pop not one cycle");
   // moves out of the accumulator and the idle word leave it alone
   chk_acc_keep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && (a2f || a2s || idl) |=> $stable(acc_r)) else $error("acc changed on write");
   // loads into the accumulator never write anything outside
   chk_load_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && (f2a || l2a) |=> !fwe_r && !swe_r && !pop_r) else $error("load wrote out");
   // address and data land with their strobe, except that file_addr_o shows the field of any word taken in the strobe cycle
   chk_file_addr: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && a2f |=> faddr_r == $past(instr_i[6:0])) else $error("file addr bad");
   chk_spec_data: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && a2s |=> swd_r == $past(acc_r)) else $error("spec data bad");
   // a plain subroutine exit must not touch the interrupt enable
   chk_sub_gie: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      exec_w && sxit |=> pop_r && gie_r == $past(gie_r)) else $error("sub exit moved gie");
   // nothing in this group but reset clears the enable once it is set
   chk_gie_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      gie_r |=> gie_r) else $error("gie dropped");
endmodule

// *** src/mri_opdec.sv ***
`include "mri_consts.svh"
// ****************************************
// pure opcode classifier
// ****************************************
module mri_opdec
   import mri_pkg::*;
(
   input  wire mri_pkg::mri_instr_t instr_i,
   output logic                     file_to_acc_o,
   output logic                     lit_to_acc_o,
   output logic                     acc_to_file_o,
   output logic                     acc_to_spec_o,
   output logic                     idle_o,
   output logic                     sub_exit_o,
   output logic                     int_exit_o
);
   // field matches; idle is checked before the special-register form
   assign idle_o        = (instr_i == `MRI_OP_IDLE);
   assign file_to_acc_o = (instr_i[13:7] == `MRI_OP_FILE_TO_ACC_HI);
   assign lit_to_acc_o  = (instr_i[13:8] == `MRI_OP_LIT_TO_ACC_HI);
   assign acc_to_file_o = (instr_i[13:7] == `MRI_OP_ACC_TO_FILE_HI);
   assign acc_to_spec_o = (instr_i[13:6] == `MRI_OP_ACC_TO_SPEC_HI) && !idle_o;
   assign sub_exit_o    = (instr_i == `MRI_OP_SUB_EXIT);
   assign int_exit_o    = (instr_i == `MRI_OP_INT_EXIT);
endmodule

// *** src/mri_pkg.sv ***
package mri_pkg;
   typedef logic [13:0] mri_instr_t;
   typedef logic [10:0] mri_pc_t;
   typedef logic [7:0]  mri_byte_t;
   typedef enum logic [0:0] {
      MRI_ST_EXEC  = 1'b0,
      MRI_ST_FLUSH = 1'b1
   } mri_state_t;
endpackage

// *** verif/move_and_return_instr_decode_tb_top.sv ***
module move_and_return_instr_decode_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import mri_pkg::*;
   logic       ref_clk_i = 1'b0;
   logic       rst_i = 1'b1;
   mri_instr_t instr_i = 14'h0000;
   logic       instr_valid_i = 1'b0;
   mri_byte_t  file_rdata, accumulator_o, file_wdata_o, spec_wdata_o;
   mri_pc_t    stack_top, pc_o, exp_pc;
   logic [6:0] file_addr_o;
   logic [5:0] spec_addr_o;
   logic       instr_ready_o, file_we_o, spec_we_o, stack_pop_o, gie_o, flags_we_o;
   int         errors = 0;
   int         cmp_count = 0;
   // ****************************************
   // design and far side
   // ****************************************
   mri_decode dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_i(instr_i),
      .instr_valid_i(instr_valid_i), .file_rdata_i(file_rdata),
      .stack_top_entry_i(stack_top), .instr_ready_o(instr_ready_o),
      .accumulator_o(accumulator_o), .pc_o(pc_o), .file_addr_o(file_addr_o),
      .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .spec_addr_o(spec_addr_o),
      .spec_we_o(spec_we_o), .spec_wdata_o(spec_wdata_o), .stack_pop_o(stack_pop_o),
      .global_interrupt_enable_o(gie_o), .flags_we_o(flags_we_o));
   mri_far_model far_u (.file_addr_i(file_addr_o), .file_rdata_o(file_rdata),
      .stack_top_o(stack_top));
   // free-running core clock
   always #25 ref_clk_i = ~ref_clk_i;
   task automatic cmp_val(input string what, input logic [10:0] exp, input logic [10:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // one word, taken at the rising edge, judged at the next falling edge
   task automatic issue(input mri_instr_t w);
      @(negedge ref_clk_i);
      instr_i = w;
      instr_valid_i = 1'b1;
      @(negedge ref_clk_i);
      instr_valid_i = 1'b0;
      exp_pc = exp_pc + 11'h001;
   endtask
   task automatic chk_core(input mri_byte_t acc, input logic fw, sw, pop);
      cmp_val("acc", acc, accumulator_o);
      cmp_val("pc", exp_pc, pc_o);
      cmp_val("file_we", fw, file_we_o);
      cmp_val("spec_we", sw, spec_we_o);
      cmp_val("pop", pop, stack_pop_o);
      cmp_val("flags_we", 1'b0, flags_we_o);
   endtask
   task automatic t_moves;
      issue(14'h19FF); chk_core(8'hFF, 1'b0, 1'b0, 1'b0);
      issue(14'h1900); chk_core(8'h00, 1'b0, 1'b0, 1'b0);
      issue(14'h087F); chk_core({1'b1, 7'h7F} ^ 8'h5A, 1'b0, 1'b0, 1'b0);
      issue(14'h00FF); chk_core(8'hA5, 1'b1, 1'b0, 1'b0);
      cmp_val("file_addr", 7'h7F, file_addr_o);
      cmp_val("file_wdata", 8'hA5, file_wdata_o);
      issue(14'h003F); chk_core(8'hA5, 1'b0, 1'b1, 1'b0);
      cmp_val("spec_addr", 6'h3F, spec_addr_o);
      cmp_val("spec_wdata", 8'hA5, spec_wdata_o);
      issue(14'h0000); chk_core(8'hA5, 1'b0, 1'b0, 1'b0);
   endtask
   // return: counter reloads, the dead cycle drops a literal load, fetch resumes
   task automatic t_return(input mri_instr_t w, input logic global_interrupt_enable);
      @(negedge ref_clk_i);
      instr_i = w;
      instr_valid_i = 1'b1;
      @(negedge ref_clk_i);
      instr_i = 14'h19C3;
      exp_pc = stack_top;
      chk_core(8'hA5, 1'b0, 1'b0, 1'b1);
      cmp_val("ready", 1'b0, instr_ready_o);
      cmp_val("gie", global_interrupt_enable, gie_o);
      @(negedge ref_clk_i);
      instr_valid_i = 1'b0;
      chk_core(8'hA5, 1'b0, 1'b0, 1'b0);
      cmp_val("ready", 1'b1, instr_ready_o);
      issue(14'h0000); chk_core(8'hA5, 1'b0, 1'b0, 1'b0);
   endtask
   task automatic wrap_up;
      $display("compares %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      exp_pc = 11'h000;
      repeat (16) @(negedge ref_clk_i);
      rst_i = 1'b0;
      chk_core(8'h00, 1'b0, 1'b0, 1'b0);
      cmp_val("gie", 1'b0, gie_o);
      t_moves();
      t_return(14'h0040, 1'b0);
      t_return(14'h0060, 1'b1);
      wrap_up();
   end
   // whole run is well under a hundred cycles
   initial begin
      repeat (400) @(posedge ref_clk_i);
      errors++;
      wrap_up();
   end
endmodule

// *** verif/mri_far_model.sv ***
// ****************************************
// file register and return stack stand-in
// ****************************************
module mri_far_model
   import mri_pkg::*;
(
   input  wire logic [6:0]    file_addr_i,
   output mri_pkg::mri_byte_t file_rdata_o,
   output mri_pkg::mri_pc_t   stack_top_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // data follows the address, so a wrong index is caught
   assign file_rdata_o = {1'b1, file_addr_i} ^ 8'h5A;
   assign stack_top_o  = 11'h5A3; // far from the counter, so a missed load shows
endmodule
